// file: hw/sas_sequencer.sv
// Control and sequencing for a 10-bit SAR converter
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Each conversion resolves a 10-bit code by successive approximation.
// - Mode 00 disabled, 01 software start, 10 reserved, 11 repeat.
// - Four-bit channel code selects one of sixteen inputs.
// - Analog input disable bit: 0 enables inputs, 1 disables them.
// - In software mode, writing start 1 begins one conversion.
// - Start bit clears itself once conversion begins.
// - On completion store result, set done and pulse interrupt together.
// - Repeat mode restarts the selected channel after each completion.
// - Mode 00 during repeat aborts at once; partial result discarded.
// - After control A written 00H, starts refused for four cycles.
// - In stop mode both controls reset and ignore writes.
// - Ladder 0: connected only while converting; 1: always connected.
// - Time codes 000,010..110 give 39..1248 clocks; 001 and 111 reserved.
// - Control B bits 7 and 6 read undefined.
// - Reading high result clears done; read low first.
// - Busy sets on conversion start and clears on finish.
// - Busy also clears on entering stop mode.
// - Low result bits 3 to 0 read unstable.
// - Upper 8 result bits in high register, lower 2 in low.
// - New start clears done; old result held until new completion.
module sas_sequencer
    import sas_pkg::*;
(
    input wire logic mclk, // 100 MHz system clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [7:0] addr, // Register address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after rd_en
    input wire logic stop_mode, // Device in stop power mode
    input wire logic cmp_hi, // Comparator result
    output logic [9:0] dac_code, // Trial code to ladder
    output logic ladder_connect, // Ladder connected
    output logic [3:0] channel_select, // Selected analog input
    output logic analog_in_disable, // Inputs disabled
    output logic sample_en, // Sample-hold tracking
    output logic conv_busy_flag, // Conversion in progress
    output logic conv_done_irq // Completion pulse
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ctrl_a_reg, ctrl_a_next;
    logic [7:0] ctrl_b_reg, ctrl_b_next;
    logic [7:0] res_hi_reg, res_hi_next;
    logic [1:0] res_lo_reg, res_lo_next;
    logic done_reg, done_next;
    logic irq_reg, irq_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [2:0] hold_reg, hold_next;
    logic [10:0] cnt_reg, cnt_next;
    logic [10:0] step_reg, step_next;
    logic ladder_reg, sample_reg, busy_reg;
    sas_state_t state_reg, state_next;

    logic [9:0] trial;
    logic last_bit;

    // Clock count per conversion for a time code; reserved codes use the slowest
    function automatic logic [10:0] conv_clocks(input logic [2:0] code);
        case (code)
            3'h0: conv_clocks = SAS_T39;
            3'h2: conv_clocks = SAS_T78;
            3'h3: conv_clocks = SAS_T156;
            3'h4: conv_clocks = SAS_T312;
            3'h5: conv_clocks = SAS_T624;
            3'h6: conv_clocks = SAS_T1248;
            default: conv_clocks = SAS_T1248;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire [1:0] mode = ctrl_a_reg[SAS_A_MODE_HI:SAS_A_MODE_LO];
    wire wr_a = wr_en && !stop_mode && (addr == SAS_OFS_CTRL_A);
    wire wr_b = wr_en && !stop_mode && (addr == SAS_OFS_CTRL_B);
    wire rd_hi = rd_en && (addr == SAS_OFS_RES_HI);
    wire converting = (state_reg == SAS_CONV);
    wire mode_run = (mode == SAS_MODE_SW) || (mode == SAS_MODE_REP);
    wire [10:0] total = conv_clocks(ctrl_b_reg[SAS_B_TIME_HI:SAS_B_TIME_LO]);
    // Ten bit decisions spread evenly; first decision after sampling share
    // Steps end on last_bit, not on a count, so short time codes get all nine
    wire [10:0] per_bit = total / 11'd11;
    wire step_p = converting && (step_reg == '0) && !last_bit && (cnt_reg > 11'd1);
    wire finish = converting && (cnt_reg == 11'd1);
    wire abort = converting && !mode_run;
    // A start is accepted only in a running mode and outside the hold-off
    wire go_sw = ctrl_a_reg[SAS_A_START_BIT] && mode_run && (hold_reg == '0);
    wire go_rep = finish && (mode == SAS_MODE_REP);
    wire begin_p = !stop_mode && ((state_reg == SAS_IDLE && go_sw) || go_rep);

    sas_sar_core u_core (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .begin_p(begin_p),
        .abort(abort || stop_mode),
        .step_p(step_p),
        .cmp_hi(cmp_hi),
        .trial(trial),
        .last_bit(last_bit)
    );

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Start bit self-clears on begin; a write in that same cycle still lands
    always_comb begin
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        hold_next = (hold_reg != '0) ? hold_reg - 3'd1 : hold_reg;
        if (begin_p && state_reg == SAS_IDLE) begin
            ctrl_a_next[SAS_A_START_BIT] = 1'b0;
        end
        if (wr_a) begin
            ctrl_a_next = wdata;
            if (wdata == SAS_CTRL_A_ZERO) begin
                hold_next = SAS_START_HOLD;
            end
        end
        if (wr_b) begin
            ctrl_b_next = wdata;
        end
        if (stop_mode) begin
            ctrl_a_next = SAS_CTRL_A_RST;
            ctrl_b_next = SAS_CTRL_B_RST;
            hold_next = '0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        step_next = step_reg;
        case (state_reg)
            SAS_IDLE: begin
                if (begin_p) begin
                    state_next = SAS_CONV;
                    cnt_next = total;
                    step_next = per_bit;
                end
            end
            SAS_CONV: begin
                if (stop_mode || abort) begin
                    state_next = SAS_IDLE;
                end else if (finish) begin
                    if (go_rep) begin
                        cnt_next = total;
                        step_next = per_bit;
                    end else begin
                        state_next = SAS_IDLE;
                    end
                end else begin
                    cnt_next = cnt_reg - 11'd1;
                    step_next = (step_reg == '0) ? per_bit : step_reg - 11'd1;
                end
            end
            default: state_next = SAS_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Result, done flag and interrupt
    // ------------------------------------------------------------
    // Final decision folded in here, so result matches the last comparator
    wire [9:0] final_code = last_bit ? (cmp_hi ? trial : (trial & 10'h3FE)) : trial;
    always_comb begin
        res_hi_next = res_hi_reg;
        res_lo_next = res_lo_reg;
        done_next = done_reg;
        irq_next = 1'b0;
        if (rd_hi) begin
            done_next = 1'b0;
        end
        if (begin_p) begin
            done_next = 1'b0;
        end
        if (finish && !stop_mode && mode_run) begin
            res_hi_next = final_code[9:2];
            res_lo_next = final_code[1:0];
            done_next = 1'b1;
            irq_next = 1'b1;
        end
        if (stop_mode) begin
            done_next = 1'b0;
            res_hi_next = '0;
            res_lo_next = '0;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Undefined and unstable bits are driven as zero for determinism
    always_comb begin
        rdata_next = '0;
        if (rd_en) begin
            case (addr)
                SAS_OFS_CTRL_A: rdata_next = ctrl_a_reg;
                SAS_OFS_CTRL_B: rdata_next = {2'b00, ctrl_b_reg[5:0]};
                SAS_OFS_RES_HI: rdata_next = res_hi_reg;
                SAS_OFS_RES_LO: rdata_next = {res_lo_reg, done_reg, converting, 4'h0};
                default: rdata_next = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------
    // Control registers; stop mode forces reset values through the next state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_a_reg <= SAS_CTRL_A_RST;
            ctrl_b_reg <= SAS_CTRL_B_RST;
        end else begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
        end
    end

    // Start hold-off after control A is cleared
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hold_reg <= '0;
        end else begin
            hold_reg <= hold_next;
        end
    end

    // Sequencer state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= SAS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Conversion length and bit-step counters
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            step_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            step_reg <= step_next;
        end
    end

    // Result registers; a completed conversion loads them, stop mode clears them
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            res_hi_reg <= '0;
            res_lo_reg <= '0;
        end else begin
            res_hi_reg <= res_hi_next;
            res_lo_reg <= res_lo_next;
        end
    end

    // Done flag
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    // Completion pulse, one cycle per conversion
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Ladder follows the connect bit or activity, registered for the pin
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ladder_reg <= 1'b0;
        end else begin
            ladder_reg <= ctrl_b_next[SAS_B_LADDER_BIT] || (state_next == SAS_CONV);
        end
    end

    // Sample-hold opens in the first cycle of each conversion
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sample_reg <= 1'b0;
        end else begin
            sample_reg <= (state_next == SAS_CONV) && (step_next == per_bit)
                && (cnt_next == total);
        end
    end

    // Busy taken from the next state, so it tracks state_reg without a decode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next == SAS_CONV);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every pin-facing output is a flop or a slice of one
    assign rdata = rdata_reg;
    assign dac_code = trial;
    assign ladder_connect = ladder_reg;
    assign channel_select = ctrl_a_reg[3:0];
    assign analog_in_disable = ctrl_a_reg[SAS_A_AIN_DIS_BIT];
    assign sample_en = sample_reg;
    assign conv_busy_flag = busy_reg;
    assign conv_done_irq = irq_reg;
endmodule
`default_nettype wire

// file: hw/sas_pkg.sv
// Package of constants for the SAR converter sequencer
package sas_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SAS_OFS_CTRL_A = 8'h26;
    localparam logic [7:0] SAS_OFS_CTRL_B = 8'h27;
    localparam logic [7:0] SAS_OFS_RES_HI = 8'h28;
    localparam logic [7:0] SAS_OFS_RES_LO = 8'h29;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int SAS_A_START_BIT = 7;
    localparam int SAS_A_MODE_HI = 6;
    localparam int SAS_A_MODE_LO = 5;
    localparam int SAS_A_AIN_DIS_BIT = 4;
    localparam int SAS_B_LADDER_BIT = 5;
    localparam int SAS_B_FIXED1_BIT = 4;
    localparam int SAS_B_TIME_HI = 3;
    localparam int SAS_B_TIME_LO = 1;
    localparam int SAS_L_DONE_BIT = 5;
    localparam int SAS_L_BUSY_BIT = 4;
    localparam logic [7:0] SAS_CTRL_A_RST = 8'h10;
    localparam logic [7:0] SAS_CTRL_B_RST = 8'h10;
    localparam logic [7:0] SAS_CTRL_A_ZERO = 8'h00;
    localparam int SAS_RES_BITS = 10;

    // ------------------------------------------------------------
    // Modes and timing
    // ------------------------------------------------------------
    localparam logic [1:0] SAS_MODE_OFF = 2'h0;
    localparam logic [1:0] SAS_MODE_SW = 2'h1;
    localparam logic [1:0] SAS_MODE_REP = 2'h3;
    localparam logic [2:0] SAS_START_HOLD = 3'h4;
    localparam int SAS_CNT_W = 11;
    localparam logic [10:0] SAS_T39 = 11'h027;
    localparam logic [10:0] SAS_T78 = 11'h04E;
    localparam logic [10:0] SAS_T156 = 11'h09C;
    localparam logic [10:0] SAS_T312 = 11'h138;
    localparam logic [10:0] SAS_T624 = 11'h270;
    localparam logic [10:0] SAS_T1248 = 11'h4E0;

    typedef enum logic [1:0] {
        SAS_IDLE = 2'b01,
        SAS_CONV = 2'b10
    } sas_state_t;
endpackage

// file: hw/sas_sar_core.sv
// Successive-approximation bit search core
`timescale 1ns/10ps
`default_nettype none
module sas_sar_core
    import sas_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic begin_p, // Start a new search
    input wire logic abort, // Drop the search in progress
    input wire logic step_p, // Resolve the next bit
    input wire logic cmp_hi, // Comparator: input above trial
    output logic [9:0] trial, // Trial code to the ladder
    output logic last_bit // Only the lowest bit left to resolve
);
    // ------------------------------------------------------------
    // Bit search
    // ------------------------------------------------------------
    logic [9:0] trial_reg, trial_next;
    logic [9:0] mask_reg, mask_next;

    // Keep bit if comparator says input is above, then try next lower bit
    always_comb begin
        trial_next = trial_reg;
        mask_next = mask_reg;
        if (abort) begin
            mask_next = '0;
        end else if (begin_p) begin
            mask_next = 10'h200;
            trial_next = 10'h200;
        end else if (step_p && mask_reg != '0) begin
            trial_next = (cmp_hi ? trial_reg : (trial_reg & ~mask_reg)) | (mask_reg >> 1);
            mask_next = mask_reg >> 1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            trial_reg <= '0;
            mask_reg <= '0;
        end else begin
            trial_reg <= trial_next;
            mask_reg <= mask_next;
        end
    end

    assign trial = trial_reg;
    assign last_bit = (mask_reg == 10'h001);
endmodule
`default_nettype wire

// file: dv/sas_properties.sv
// Port-level timing checker for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_properties
    import sas_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [7:0] addr, // Address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    input wire logic [7:0] rdata, // Read data
    input wire logic stop_mode, // Stop mode
    input wire logic ladder_connect, // Ladder
    input wire logic sample_en, // Sample-hold tracking
    input wire logic conv_busy_flag, // Busy
    input wire logic conv_done_irq // Done pulse
);
    wire logic wr_a = wr_en && addr == SAS_OFS_CTRL_A;
    logic [2:0] since_zero_reg;
    // Cycles since control A was cleared; saturates so old clears drop out
    always_ff @(posedge mclk) begin
        if (sys_rst || (wr_a && wdata == SAS_CTRL_A_ZERO)) begin
            since_zero_reg <= 3'h0;
        end else if (since_zero_reg != 3'h7) begin
            since_zero_reg <= since_zero_reg + 3'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // Start, abort, completion, stop mode, ladder and sample-hold
    // ------------------------------------------------------------
    sequence s_sw_start;
        wr_a && wdata[7:5] == 3'h5 && !stop_mode && !conv_busy_flag && since_zero_reg == 3'h7;
    endsequence
    sequence s_mode_off;
        wr_a && wdata[6:5] == SAS_MODE_OFF;
    endsequence
    a_start_begins: assert property (s_sw_start |-> ##2 conv_busy_flag)
        else $error("start write did not begin a conversion");
    a_start_hold: assert property (wr_a && wdata == SAS_CTRL_A_ZERO |-> ##2 !conv_busy_flag [*4])
        else $error("conversion began inside the hold after clearing");
    a_abort_quiet: assert property (s_mode_off |-> ##2 !conv_done_irq [*6])
        else $error("completion after mode set to off");
    a_irq_single: assert property (conv_done_irq |=> !conv_done_irq)
        else $error("completion pulse longer than one cycle");
    a_irq_busy: assert property (conv_done_irq |-> $past(conv_busy_flag))
        else $error("completion without a conversion");
    a_stop_idle: assert property (stop_mode |=> !conv_busy_flag)
        else $error("busy in stop mode");
    a_stop_regs: assert property (rd_en && addr == SAS_OFS_CTRL_A && stop_mode
        && $past(stop_mode) |=> rdata == SAS_CTRL_A_RST)
        else $error("control A not at reset value in stop mode");
    a_ladder_conv: assert property (conv_busy_flag && $past(conv_busy_flag) |-> ladder_connect)
        else $error("ladder open during conversion");
    a_sample_first: assert property ($rose(conv_busy_flag) |-> sample_en)
        else $error("sample-hold not opened as the conversion began");
endmodule
bind sas_sequencer sas_properties i_props (.mclk(mclk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .stop_mode(stop_mode),
    .ladder_connect(ladder_connect), .sample_en(sample_en), .conv_busy_flag(conv_busy_flag),
    .conv_done_irq(conv_done_irq));
`default_nettype wire

// file: dv/sas_cmp_model.sv
// Analog front end model: sixteen input levels and a comparator
`timescale 1ns/10ps
`default_nettype none
module sas_cmp_model
    import sas_pkg::*;
(
    input wire logic [9:0] dac_code, // Trial code
    input wire logic [3:0] channel_select, // Chosen input
    input wire logic analog_in_disable, // Inputs off
    output logic cmp_hi // Input above trial
);
    logic [9:0] level [16]; // Input levels, set by the bench
    // Inputs sit half a step above their code, so either rounding settles on it
    assign cmp_hi = !analog_in_disable && ({level[channel_select], 1'b1} > {dac_code, 1'b0});
endmodule
`default_nettype wire

// file: dv/tb_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_sequencer
    import sas_pkg::*;
;
    localparam int T_TAB [8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248};
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic stop_mode = 1'b0;
    logic rd_q = 1'b0;
    logic cmp_hi, ladder_connect, analog_in_disable, sample_en, conv_busy_flag, conv_done_irq;
    logic [7:0] rdata;
    logic [9:0] dac_code;
    logic [3:0] channel_select;
    logic [15:0] notes [$]; // Mask and expected read value
    logic [15:0] nt;
    logic [31:0] rng = 32'h5A26;
    int miscompares = 0;
    int comparisons = 0;
    always #5 mclk = ~mclk;
    sas_sequencer i_dut (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .stop_mode(stop_mode), .cmp_hi(cmp_hi),
        .dac_code(dac_code), .ladder_connect(ladder_connect), .channel_select(channel_select),
        .analog_in_disable(analog_in_disable), .sample_en(sample_en),
        .conv_busy_flag(conv_busy_flag), .conv_done_irq(conv_done_irq));
    sas_cmp_model i_afe (.dac_code(dac_code), .channel_select(channel_select),
        .analog_in_disable(analog_in_disable), .cmp_hi(cmp_hi));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic end_of_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobes are set in every call so back-to-back cycles never drive twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        notes.push_back({m, v & m});
        addr <= a;
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge mclk);
    endtask
    task automatic idle(input int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (conv_done_irq !== 1'b1 && n < lim);
        if (conv_done_irq !== 1'b1) begin
            miscompares++;
            $display("[ERR] t=%0t waited=%h limit=%h", $time, n, lim);
            end_of_test();
        end
    endtask
    // Read data lands one cycle after the strobe; oldest note is compared
    always @(posedge mclk) begin
        if (rd_q) begin
            nt = notes.pop_front();
            check(rdata & nt[15:8], nt[7:0]);
        end
        rd_q <= rd_en;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [9:0] v;
        logic [9:0] pv;
        logic [3:0] ch;
        realtime t0;
        pv = 10'h000;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(SAS_OFS_CTRL_A, 8'hFF, SAS_CTRL_A_RST);
        rd(SAS_OFS_CTRL_B, 8'h3F, 8'h10);
        rd(SAS_OFS_RES_HI, 8'hFF, 8'h00);
        rd(SAS_OFS_RES_LO, 8'hF0, 8'h00);
        rd(8'h40, 8'hFF, 8'h00);
        idle(2);
        check(analog_in_disable, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            ch = rng[3:0];
            v = rng[13:4];
            i_afe.level[ch] = v;
            wr(SAS_OFS_CTRL_B, {2'h0, i[0], 1'b1, i[2:0], 1'b0});
            wr(SAS_OFS_CTRL_A, {4'h2, ch});
            wr(SAS_OFS_CTRL_A, {4'hA, ch});
            t0 = $realtime;
            idle(1);
            rd(SAS_OFS_CTRL_A, 8'hFF, {4'h2, ch});
            rd(SAS_OFS_RES_LO, 8'h30, 8'h10);
            rd(SAS_OFS_RES_HI, 8'hFF, pv[9:2]);
            idle(1);
            check({analog_in_disable, channel_select}, {1'b0, ch});
            wait_irq(1400);
            check((($realtime - t0) / 10 >= T_TAB[i] && ($realtime - t0) / 10 <= T_TAB[i] + 3)
                ? T_TAB[i] : ($realtime - t0) / 10, T_TAB[i]);
            rd(SAS_OFS_RES_LO, 8'hF0, {v[1:0], 2'h2, 4'h0});
            if (i != 3) begin
                rd(SAS_OFS_RES_HI, 8'hFF, v[9:2]);
                rd(SAS_OFS_RES_LO, 8'h20, 8'h00);
            end
            idle(2);
            check(ladder_connect, i[0]);
            pv = v;
        end
        $display("test single conversions done");
        ch = 4'h9;
        v = 10'h2C5;
        i_afe.level[ch] = v;
        wr(SAS_OFS_CTRL_B, 8'h1C);
        wr(SAS_OFS_CTRL_A, 8'h00);
        wr(SAS_OFS_CTRL_A, {4'hE, ch});
        idle(3);
        check(conv_busy_flag, 1'b0);
        repeat (3) wait_irq(1400);
        i_afe.level[ch] = 10'h0F3;
        idle(10);
        wr(SAS_OFS_CTRL_A, {4'h0, ch});
        idle(60);
        check(conv_busy_flag, 1'b0);
        rd(SAS_OFS_RES_HI, 8'hFF, v[9:2]);
        wr(SAS_OFS_CTRL_A, {4'hC, ch});
        idle(6);
        check(conv_busy_flag, 1'b0);
        $display("test repeat and abort done");
        wr(SAS_OFS_CTRL_A, {4'hA, ch});
        idle(8);
        stop_mode <= 1'b1;
        idle(2);
        check(conv_busy_flag, 1'b0);
        wr(SAS_OFS_CTRL_A, 8'h65);
        wr(SAS_OFS_CTRL_B, 8'h3C);
        rd(SAS_OFS_CTRL_A, 8'hFF, SAS_CTRL_A_RST);
        rd(SAS_OFS_CTRL_B, 8'h3F, 8'h10);
        rd(SAS_OFS_RES_LO, 8'hF0, 8'h00);
        idle(2);
        stop_mode <= 1'b0;
        idle(4);
        $display("test stop mode done");
        end_of_test();
    end
endmodule
`default_nettype wire
